// file: core/ccg_pkg.sv
// Constants for the codec clock generation and PLL control block.
// Assumes a single core clock; source clocks arrive as one-cycle ticks.
//
// Overview of operation
// [RULE1] Right-justified with 32-bit words runs as 24-bit
// [RULE2] Source select: 0 master clock, 1 PLL
// [RULE3] System divider codes map to 1,2,3,4,6,8,12
// [RULE4] Bit clock divider: powers of two up to 32
// [RULE5] Master drives bit/frame clocks, slave receives them
// [RULE6] ADC loopback feeds ADC output into DAC input
// [RULE7] DAC loopback feeds DAC output into ADC input
// [RULE8] Sample rate field selects filter coefficient set
// [RULE9] Rate-derived timings assume system clock of 256fs
// [RULE10] Software picks nearest listed sample rate code
// [RULE11] PLL enable bit switches the PLL on
// [RULE12] PLL held off while reference select is zero
// [RULE13] Software computes integer and fractional ratio words
// [RULE14] PLL output divided by four, then system divider
// [RULE15] Fractional enable bit permits fractional PLL division
// [RULE16] Prescale field conditions master clock before PLL
// [RULE17] Software keeps integer word between 6 and 12
// [RULE18] Fraction word assembled from three registers
// [RULE19] PLL derived clock offered on general-purpose pin
// [RULE20] Bit clock restarts each frame, may shorten pulse
// [RULE21] Divider code 010 divides by two; power-off bit

package ccg_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [5:0] OFS_POWER_MANAGEMENT_ONE     = 6'h01;
  localparam logic [5:0] OFS_AUDIO_FORMAT             = 6'h04;
  localparam logic [5:0] OFS_LOOPBACK_CONTROL         = 6'h05;
  localparam logic [5:0] OFS_CLOCK_GENERATION_CONTROL = 6'h06;
  localparam logic [5:0] OFS_ADDITIONAL_CONTROL       = 6'h07;
  localparam logic [5:0] OFS_CLOCK_STATUS             = 6'h08;
  localparam logic [5:0] OFS_PLL_INTEGER_AND_CONTROL  = 6'h24;
  localparam logic [5:0] OFS_PLL_FRACTION_HIGH        = 6'h25;
  localparam logic [5:0] OFS_PLL_FRACTION_MID         = 6'h26;
  localparam logic [5:0] OFS_PLL_FRACTION_LOW         = 6'h27;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [8:0] RST_POWER_MANAGEMENT_ONE     = 9'h000;
  localparam logic [8:0] RST_AUDIO_FORMAT             = 9'h050;
  localparam logic [8:0] RST_LOOPBACK_CONTROL         = 9'h000;
  localparam logic [8:0] RST_CLOCK_GENERATION_CONTROL = 9'h140;
  localparam logic [8:0] RST_ADDITIONAL_CONTROL       = 9'h000;
  localparam logic [8:0] RST_PLL_INTEGER_AND_CONTROL  = 9'h048;
  localparam logic [8:0] RST_PLL_FRACTION_HIGH        = 9'h00C;
  localparam logic [8:0] RST_PLL_FRACTION_MID         = 9'h093;
  localparam logic [8:0] RST_PLL_FRACTION_LOW         = 9'h0E9;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_VMID_LO      = 0;  // Reference voltage select [1:0]
  localparam int BIT_PLL_ENABLE   = 5;
  localparam int BIT_CLK_SOURCE   = 8;
  localparam int BIT_SYSDIV_LO    = 5;  // System divider [7:5]
  localparam int BIT_BIT_CLOCK_DIVIDER_LO   = 2;  // Bit clock divider [4:2]
  localparam int BIT_MASTER       = 0;
  localparam int BIT_RATE_LO      = 1;  // Sample rate [3:1]
  localparam int BIT_PLL_OFF      = 7;
  localparam int BIT_FRAC_EN      = 6;
  localparam int BIT_PRESCALE_LO  = 4;  // Prescale [5:4]
  localparam int BIT_INT_LO       = 0;  // Integer word [3:0]
  localparam int BIT_WLEN_LO      = 5;  // Word length [6:5]
  localparam int BIT_FMT_LO       = 3;  // Format [4:3]
  localparam int BIT_DAC_LOOP     = 6;
  localparam int BIT_ADC_LOOP     = 0;

  // ------------------------------------------------------------
  // Encodings and timing counts
  // ------------------------------------------------------------
  localparam logic [1:0] FMT_RIGHT_JUSTIFIED = 2'h0;
  localparam logic [1:0] WLEN_24_BITS        = 2'h2;
  localparam logic [1:0] WLEN_32_BITS        = 2'h3;
  localparam logic [1:0] VMID_OFF            = 2'h0;
  localparam logic [2:0] RATE_LAST_VALID     = 3'h5;
  localparam logic [1:0] PLL_POST_DIV_LAST   = 2'h3;  // Fixed divide by 4
  localparam logic [7:0] FRAME_TICKS_LAST    = 8'hFF; // 256 system ticks per frame
  localparam logic [7:0] FRAME_HALF          = 8'h80;

  // Run states of the selected clock path
  typedef enum logic [1:0]
  {
    PATH_STOPPED = 2'b00,
    PATH_MCLK    = 2'b01,
    PATH_PLL     = 2'b10
  } path_type;

endpackage

// file: core/ccg_top.sv
// Clock generation, PLL control and loopback routing for the codec core.
// Source clocks arrive as one-cycle ticks synchronous to CORE_CLK.
// The analog PLL lives outside; this block drives its control words.

`timescale 1ns/1ps
`default_nettype none

module ccg_top
(
  // Core clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       NRST,
  // Register port
  input  wire logic [5:0] REG_ADDR,
  input  wire logic [8:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [8:0] REG_RDATA,
  // Source clock ticks
  input  wire logic       MCLK_TICK,
  input  wire logic       PLL_TICK,
  // PLL control words
  output logic            PLL_ENABLE,
  output logic            PLL_FRAC_EN,
  output logic      [1:0] PLL_PRESCALE,
  output logic      [3:0] PLL_INT_WORD,
  output logic     [23:0] PLL_FRAC_WORD,
  output logic            GPIO_CLK,
  // System clock
  output logic            SYS_CLK_TICK,
  output logic            SYS_CLK_OUT,
  // Bit and frame clock pins
  input  wire logic       BCLK_I,
  output logic            BCLK_O,
  output logic            BCLK_OE,
  input  wire logic       FRAME_I,
  output logic            FRAME_O,
  output logic            FRAME_OE,
  output logic            BCLK_INT,
  output logic            FRAME_INT,
  // Filter and format controls
  output logic      [2:0] FILTER_COEF_SEL,
  output logic            RATE_VALID,
  output logic      [1:0] EFF_WORD_LEN,
  // Loopback data paths
  input  wire logic       ADC_IF_DATA,
  input  wire logic       DAC_PIN_DATA,
  input  wire logic       DAC_IF_DATA,
  input  wire logic       ADC_CORE_DATA,
  output logic            DAC_PATH_DATA,
  output logic            ADC_PATH_DATA
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // System divider code to last count value (divide minus one)
  function automatic logic [3:0] sys_div_last(input logic [2:0] code);
    case (code)
      3'h0:    sys_div_last = 4'h0;
      3'h1:    sys_div_last = 4'h1;
      3'h2:    sys_div_last = 4'h1;  // Reset code divides by two
      3'h3:    sys_div_last = 4'h2;
      3'h4:    sys_div_last = 4'h3;
      3'h5:    sys_div_last = 4'h5;
      3'h6:    sys_div_last = 4'h7;
      default: sys_div_last = 4'hB;
    endcase
  endfunction

  // Bit clock divider code to last count; reserved codes hold at 32
  function automatic logic [4:0] bclk_div_last(input logic [2:0] code);
    case (code)
      3'h0:    bclk_div_last = 5'h00;
      3'h1:    bclk_div_last = 5'h01;
      3'h2:    bclk_div_last = 5'h03;
      3'h3:    bclk_div_last = 5'h07;
      3'h4:    bclk_div_last = 5'h0F;
      default: bclk_div_last = 5'h1F;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [8:0]      pwr_q;        // Power management one
  logic [8:0]      fmt_q;        // Audio format
  logic [8:0]      loop_q;       // Loopback control
  logic [8:0]      clkgen_q;     // Clock generation control
  logic [8:0]      addl_q;       // Additional control
  logic [8:0]      pllc_q;       // PLL integer and control
  logic [5:0]      frac_hi_q;    // Fraction bits 23:18
  logic [8:0]      frac_mid_q;   // Fraction bits 17:9
  logic [8:0]      frac_lo_q;    // Fraction bits 8:0
  logic [8:0]      rdata_d;      // Read mux
  logic [8:0]      status;       // Live status word
  ccg_pkg::path_type path_q;     // Active clock path

  // Register writes; unmapped offsets are ignored
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pwr_q      <= ccg_pkg::RST_POWER_MANAGEMENT_ONE;
      fmt_q      <= ccg_pkg::RST_AUDIO_FORMAT;
      loop_q     <= ccg_pkg::RST_LOOPBACK_CONTROL;
      clkgen_q   <= ccg_pkg::RST_CLOCK_GENERATION_CONTROL;
      addl_q     <= ccg_pkg::RST_ADDITIONAL_CONTROL;
      pllc_q     <= ccg_pkg::RST_PLL_INTEGER_AND_CONTROL;
      frac_hi_q  <= ccg_pkg::RST_PLL_FRACTION_HIGH[5:0];
      frac_mid_q <= ccg_pkg::RST_PLL_FRACTION_MID;
      frac_lo_q  <= ccg_pkg::RST_PLL_FRACTION_LOW;
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        ccg_pkg::OFS_POWER_MANAGEMENT_ONE:     pwr_q      <= REG_WDATA;
        ccg_pkg::OFS_AUDIO_FORMAT:             fmt_q      <= REG_WDATA;
        ccg_pkg::OFS_LOOPBACK_CONTROL:         loop_q     <= REG_WDATA;
        ccg_pkg::OFS_CLOCK_GENERATION_CONTROL: clkgen_q   <= REG_WDATA;
        ccg_pkg::OFS_ADDITIONAL_CONTROL:       addl_q     <= REG_WDATA;
        ccg_pkg::OFS_PLL_INTEGER_AND_CONTROL:  pllc_q     <= REG_WDATA;
        ccg_pkg::OFS_PLL_FRACTION_HIGH:        frac_hi_q  <= REG_WDATA[5:0];
        ccg_pkg::OFS_PLL_FRACTION_MID:         frac_mid_q <= REG_WDATA;
        ccg_pkg::OFS_PLL_FRACTION_LOW:         frac_lo_q  <= REG_WDATA;
        default:                               ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  logic       pll_run;     // PLL allowed to run
  logic       use_pll;     // Source select
  logic       master;      // Master over bit and frame clocks
  logic [2:0] sys_code;
  logic [2:0] bclk_code;
  logic [2:0] rate_code;
  logic [1:0] wlen_code;
  logic [1:0] fmt_code;

  // Enable gated by reference select and the power-off bit
  assign pll_run = pwr_q[ccg_pkg::BIT_PLL_ENABLE]                          // RULE11
                 && (pwr_q[ccg_pkg::BIT_VMID_LO +: 2] != ccg_pkg::VMID_OFF) // RULE12
                 && !pllc_q[ccg_pkg::BIT_PLL_OFF];                          // RULE21
  assign use_pll   = clkgen_q[ccg_pkg::BIT_CLK_SOURCE];
  assign master    = clkgen_q[ccg_pkg::BIT_MASTER];
  assign sys_code  = clkgen_q[ccg_pkg::BIT_SYSDIV_LO +: 3];
  assign bclk_code = clkgen_q[ccg_pkg::BIT_BIT_CLOCK_DIVIDER_LO +: 3];
  assign rate_code = addl_q[ccg_pkg::BIT_RATE_LO +: 3];
  assign wlen_code = fmt_q[ccg_pkg::BIT_WLEN_LO +: 2];
  assign fmt_code  = fmt_q[ccg_pkg::BIT_FMT_LO +: 2];

  // Status: path state, PLL run, master, pin levels
  assign status = {3'h0, FRAME_INT, BCLK_INT, master, pll_run, path_q};

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    case (REG_ADDR)
      ccg_pkg::OFS_POWER_MANAGEMENT_ONE:     rdata_d = pwr_q;
      ccg_pkg::OFS_AUDIO_FORMAT:             rdata_d = fmt_q;
      ccg_pkg::OFS_LOOPBACK_CONTROL:         rdata_d = loop_q;
      ccg_pkg::OFS_CLOCK_GENERATION_CONTROL: rdata_d = clkgen_q;
      ccg_pkg::OFS_ADDITIONAL_CONTROL:       rdata_d = addl_q;
      ccg_pkg::OFS_CLOCK_STATUS:             rdata_d = status;
      ccg_pkg::OFS_PLL_INTEGER_AND_CONTROL:  rdata_d = pllc_q;
      ccg_pkg::OFS_PLL_FRACTION_HIGH:        rdata_d = {3'h0, frac_hi_q};
      ccg_pkg::OFS_PLL_FRACTION_MID:         rdata_d = frac_mid_q;
      ccg_pkg::OFS_PLL_FRACTION_LOW:         rdata_d = frac_lo_q;
      default:                               rdata_d = 9'h000;
    endcase
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      REG_RDATA <= 9'h000;
    else
      REG_RDATA <= REG_RD ? rdata_d : 9'h000;
  end

  // ------------------------------------------------------------
  // PLL control outputs
  // ------------------------------------------------------------

  // Registered control words toward the analog PLL
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PLL_ENABLE    <= 1'b0;
      PLL_FRAC_EN   <= 1'b0;
      PLL_PRESCALE  <= 2'h0;
      PLL_INT_WORD  <= 4'h0;
      PLL_FRAC_WORD <= 24'h000000;
    end
    else
    begin
      PLL_ENABLE    <= pll_run;                                      // RULE12
      PLL_FRAC_EN   <= pllc_q[ccg_pkg::BIT_FRAC_EN];                 // RULE15
      PLL_PRESCALE  <= pllc_q[ccg_pkg::BIT_PRESCALE_LO +: 2];        // RULE16
      // Range 6..12 is software's duty; value passed unchanged
      PLL_INT_WORD  <= pllc_q[ccg_pkg::BIT_INT_LO +: 4];             // RULE17
      PLL_FRAC_WORD <= {frac_hi_q, frac_mid_q, frac_lo_q};           // RULE18
    end
  end

  // ------------------------------------------------------------
  // Source selection and dividers
  // ------------------------------------------------------------
  logic [1:0] post_cnt_q;  // Fixed divide by four on PLL ticks
  logic       src_tick;    // Selected source tick
  logic [3:0] sys_cnt_q;   // System divider count
  logic       sys_tick;

  // Only PLL ticks while running advance the fixed divider
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      post_cnt_q <= 2'h0;
    else if (pll_run && PLL_TICK)
      post_cnt_q <= post_cnt_q + 2'h1;                               // RULE14
  end

  // Source mux; a stopped PLL starves the core, by intent
  assign src_tick = use_pll ?                                        // RULE2
                    (pll_run && PLL_TICK
                     && post_cnt_q == ccg_pkg::PLL_POST_DIV_LAST) :  // RULE14
                    MCLK_TICK;

  // Path state for status readback
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      path_q <= ccg_pkg::PATH_STOPPED;
    else if (!use_pll)
      path_q <= ccg_pkg::PATH_MCLK;
    else if (pll_run)
      path_q <= ccg_pkg::PATH_PLL;
    else
      path_q <= ccg_pkg::PATH_STOPPED;
  end

  // System divider; counter restarts when the code shrinks below it
  assign sys_tick = src_tick && (sys_cnt_q >= sys_div_last(sys_code));

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      sys_cnt_q <= 4'h0;
    else if (sys_tick)
      sys_cnt_q <= 4'h0;                                             // RULE3
    else if (src_tick)
      sys_cnt_q <= sys_cnt_q + 4'h1;
  end

  // System clock tick and square wave
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      SYS_CLK_TICK <= 1'b0;
      SYS_CLK_OUT  <= 1'b0;
    end
    else
    begin
      SYS_CLK_TICK <= sys_tick;
      if (sys_tick)
        SYS_CLK_OUT <= !SYS_CLK_OUT;
    end
  end

  // Derived clock for the general-purpose pin, from the PLL path
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      GPIO_CLK <= 1'b0;
    else if (pll_run && PLL_TICK && post_cnt_q == ccg_pkg::PLL_POST_DIV_LAST)
      GPIO_CLK <= !GPIO_CLK;                                         // RULE19
  end

  // ------------------------------------------------------------
  // Bit and frame clocks
  // ------------------------------------------------------------
  logic [7:0] frame_cnt_q;  // 256 system ticks per frame
  logic [4:0] bclk_cnt_q;
  logic       frame_wrap;

  // Frame length fixed at 256fs so rate timings scale with it
  assign frame_wrap = sys_tick && frame_cnt_q == ccg_pkg::FRAME_TICKS_LAST; // RULE9

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      frame_cnt_q <= 8'h00;
    else if (sys_tick)
      frame_cnt_q <= frame_cnt_q + 8'h01;
  end

  // Bit counter restarts at each frame, so a last pulse may be short
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      bclk_cnt_q <= 5'h00;
      BCLK_O     <= 1'b0;
    end
    else if (frame_wrap)
    begin
      bclk_cnt_q <= 5'h00;                                           // RULE20
      BCLK_O     <= 1'b0;
    end
    else if (sys_tick && bclk_cnt_q >= bclk_div_last(bclk_code))
    begin
      bclk_cnt_q <= 5'h00;                                           // RULE4
      BCLK_O     <= !BCLK_O;
    end
    else if (sys_tick)
      bclk_cnt_q <= bclk_cnt_q + 5'h01;
  end

  // Frame is high for the first half of each frame
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      FRAME_O <= 1'b0;
    else
      FRAME_O <= frame_cnt_q < ccg_pkg::FRAME_HALF;
  end

  // Pin direction and the clocks seen inside
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      BCLK_OE   <= 1'b0;
      FRAME_OE  <= 1'b0;
      BCLK_INT  <= 1'b0;
      FRAME_INT <= 1'b0;
    end
    else
    begin
      BCLK_OE   <= master;                                           // RULE5
      FRAME_OE  <= master;                                           // RULE5
      BCLK_INT  <= master ? BCLK_O : BCLK_I;
      FRAME_INT <= master ? FRAME_O : FRAME_I;
    end
  end

  // ------------------------------------------------------------
  // Format, rate and loopback
  // ------------------------------------------------------------

  // Reserved rate codes pass through but are flagged invalid
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      FILTER_COEF_SEL <= 3'h0;
      RATE_VALID      <= 1'b0;
      EFF_WORD_LEN    <= 2'h0;
      DAC_PATH_DATA   <= 1'b0;
      ADC_PATH_DATA   <= 1'b0;
    end
    else
    begin
      FILTER_COEF_SEL <= rate_code;                                  // RULE8
      RATE_VALID      <= rate_code <= ccg_pkg::RATE_LAST_VALID;
      // Right-justified cannot carry 32 bits
      if (fmt_code == ccg_pkg::FMT_RIGHT_JUSTIFIED && wlen_code == ccg_pkg::WLEN_32_BITS)
        EFF_WORD_LEN <= ccg_pkg::WLEN_24_BITS;                       // RULE1
      else
        EFF_WORD_LEN <= wlen_code;
      DAC_PATH_DATA <= loop_q[ccg_pkg::BIT_ADC_LOOP] ? ADC_IF_DATA : DAC_PIN_DATA; // RULE6
      ADC_PATH_DATA <= loop_q[ccg_pkg::BIT_DAC_LOOP] ? DAC_IF_DATA : ADC_CORE_DATA; // RULE7
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  a_pll_vmid_gate: assert property ( // RULE12
    pwr_q[ccg_pkg::BIT_VMID_LO +: 2] == ccg_pkg::VMID_OFF |=> !PLL_ENABLE)
    else $error("PLL enabled with reference select off");
  a_pll_en_bit: assert property ( // RULE11
    !pwr_q[ccg_pkg::BIT_PLL_ENABLE] |=> !PLL_ENABLE)
    else $error("PLL enabled with enable bit clear");
  a_src_mclk: assert property ( // RULE2
    !use_pll && MCLK_TICK && sys_div_last(sys_code) == 4'h0 |=> SYS_CLK_TICK)
    else $error("Master clock tick lost at divide by one");
  a_post_div4: assert property ( // RULE14
    use_pll && sys_tick |-> PLL_TICK && post_cnt_q == 2'h3)
    else $error("System tick not on fourth PLL tick");
  a_sys_div: assert property ( // RULE3
    sys_tick && sys_code == 3'h2 |-> sys_cnt_q == 4'h1)
    else $error("Reset divider code not divide by two");
  a_pin_dir: assert property ( // RULE5
    $rose(master) |=> BCLK_OE && FRAME_OE)
    else $error("Master mode does not drive clock pins");
  a_adc_loop: assert property ( // RULE6
    loop_q[ccg_pkg::BIT_ADC_LOOP] |=> DAC_PATH_DATA == $past(ADC_IF_DATA))
    else $error("ADC loopback data not routed");
  a_dac_loop: assert property ( // RULE7
    loop_q[ccg_pkg::BIT_DAC_LOOP] |=> ADC_PATH_DATA == $past(DAC_IF_DATA))
    else $error("DAC loopback data not routed");
  a_rj_clamp: assert property ( // RULE1
    fmt_code == 2'h0 && wlen_code == 2'h3 |=> EFF_WORD_LEN == 2'h2)
    else $error("Right-justified 32-bit not clamped");
  a_frac_word: assert property ( // RULE18
    REG_WR && REG_ADDR == ccg_pkg::OFS_PLL_FRACTION_LOW
    |=> ##1 PLL_FRAC_WORD[8:0] == $past(REG_WDATA, 2))
    else $error("Fraction low bits not assembled");
  a_frame_bclk: assert property ( // RULE20
    frame_wrap |=> bclk_cnt_q == 5'h00 && !BCLK_O)
    else $error("Bit clock not restarted at frame");

  c_pll_path: cover property (use_pll && pll_run && sys_tick);
  c_master_frame: cover property (master && frame_wrap);
  c_loopback: cover property (loop_q[ccg_pkg::BIT_ADC_LOOP] && loop_q[ccg_pkg::BIT_DAC_LOOP]);

endmodule

`default_nettype wire

// file: verification/ccg_partner.sv
// Far-side model: reference clock ticks and slave bit and frame clocks.
// Assumes ticks are sampled on the core clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module ccg_partner
(
  // Core clock and source controls
  input  wire logic clk,
  input  wire logic run_mclk,
  input  wire logic run_pll,
  // Ticks and slave clocks
  output logic      mclk_tick,
  output logic      pll_tick,
  output logic      bclk_drv,
  output logic      frame_drv
);
  // --------------------------------------------------------------
  // Slave clock generator
  // --------------------------------------------------------------
  logic [5:0] cnt_q;  // Free count, runs even when unused
  initial cnt_q = 6'h00;
  // One tick per core cycle while a source is running
  assign mclk_tick = run_mclk;
  assign pll_tick  = run_pll;
  // Count keeps the slave clocks moving so a stuck input shows
  always @(posedge clk)
  begin
    cnt_q <= cnt_q + 6'h01;
  end
  assign bclk_drv  = cnt_q[0];
  assign frame_drv = cnt_q[5];
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the clock generation and PLL control block.
// Assumes the partner model supplies ticks and the slave clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic        CORE_CLK, NRST, REG_WR, REG_RD, run_m, run_p, mtk, ptk;
  logic [5:0]  REG_ADDR;
  logic [8:0]  REG_WDATA, REG_RDATA;
  logic        bclk_p, frame_p, bclk_o, bclk_oe, frame_o, frame_oe;
  logic        adc_if, dac_pin, dac_if, adc_core, dac_path, adc_path;
  logic        pll_en, frac_en, sys_tick, rvalid, bint, fint, gclk;
  logic [1:0]  presc, eff_wlen;
  logic [2:0]  coef;
  logic [3:0]  intw;
  logic [23:0] fracw;
  int          n_errors, n_checks, cyc, c;
  // Pin levels seen by the block: whoever enables drives the wire
  wire bclk_w  = bclk_oe ? bclk_o : bclk_p;
  wire frame_w = frame_oe ? frame_o : frame_p;
  ccg_partner prt_u (.clk(CORE_CLK), .run_mclk(run_m), .run_pll(run_p), .mclk_tick(mtk),
    .pll_tick(ptk), .bclk_drv(bclk_p), .frame_drv(frame_p));
  ccg_top dut_u (.CORE_CLK(CORE_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MCLK_TICK(mtk), .PLL_TICK(ptk),
    .PLL_ENABLE(pll_en), .PLL_FRAC_EN(frac_en), .PLL_PRESCALE(presc), .PLL_INT_WORD(intw),
    .PLL_FRAC_WORD(fracw), .GPIO_CLK(gclk), .SYS_CLK_TICK(sys_tick), .SYS_CLK_OUT(),
    .BCLK_I(bclk_w), .BCLK_O(bclk_o), .BCLK_OE(bclk_oe), .FRAME_I(frame_w), .FRAME_O(frame_o),
    .FRAME_OE(frame_oe), .BCLK_INT(bint), .FRAME_INT(fint), .FILTER_COEF_SEL(coef),
    .RATE_VALID(rvalid), .EFF_WORD_LEN(eff_wlen), .ADC_IF_DATA(adc_if), .DAC_PIN_DATA(dac_pin),
    .DAC_IF_DATA(dac_if), .ADC_CORE_DATA(adc_core), .DAC_PATH_DATA(dac_path),
    .ADC_PATH_DATA(adc_path));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  initial
  begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Counts may slip by a couple at window edges and frame wraps
  task automatic near(input string nm, input int exp, input int got);
    n_checks++;
    if (got > exp + 2 || got + 2 < exp)
    begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // Write, then let derived outputs land before any check
  task automatic wr(input logic [5:0] a, input logic [8:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask
  task automatic rd(input logic [5:0] a, input logic [8:0] exp);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(negedge CORE_CLK);
    chk("rdata", {15'h0, exp}, {15'h0, REG_RDATA});
  endtask
  // Count system tick cycles (sel 0) or rising edges of one observed signal over n cycles
  task automatic cnt(input int n, input int sel, output int k);
    logic prev;
    k = 0;
    prev = 1'b0;
    repeat (n)
    begin
      @(negedge CORE_CLK);
      if (sel == 0 && sys_tick === 1'b1) k++;
      if (sel == 1 && bclk_o === 1'b1 && prev === 1'b0) k++;
      if (sel == 2 && frame_o === 1'b1 && prev === 1'b0) k++;
      if (sel == 3 && gclk === 1'b1 && prev === 1'b0) k++;
      prev = (sel == 1) ? bclk_o : (sel == 2) ? frame_o : gclk;
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict;
    end
  end
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_regs;
    rd(6'h06, 9'h140);
    rd(6'h24, 9'h048);
    rd(6'h25, 9'h00C);
    rd(6'h26, 9'h093);
    rd(6'h27, 9'h0E9);
    rd(6'h3F, 9'h000);
    chk("int", 24'h8, {20'h0, intw});
    chk("frac", 24'h3126E9, fracw);
    chk("pll_en", 24'h0, {23'h0, pll_en});
    wr(6'h25, 9'h03F);
    wr(6'h27, 9'h155);
    chk("frac", 24'hFD2755, fracw);
    wr(6'h01, 9'h020);
    chk("pll_en", 24'h0, {23'h0, pll_en});
    wr(6'h01, 9'h021);
    chk("pll_en", 24'h1, {23'h0, pll_en});
    wr(6'h24, 9'h0C8);
    chk("pll_en", 24'h0, {23'h0, pll_en});
    wr(6'h24, 9'h038);
    chk("frac_en", 24'h0, {23'h0, frac_en});
    chk("presc", 24'h3, {22'h0, presc});
  endtask
  task t_div;
    int dv[8] = '{1, 2, 2, 3, 4, 6, 8, 12};
    for (int i = 0; i < 8; i++)
    begin
      wr(6'h06, {1'b0, i[2:0], 5'h00});
      cnt(240, 0, c);
      near("sysdiv", 240 / dv[i], c);
    end
    @(posedge CORE_CLK);
    run_m <= 1'b0; run_p <= 1'b1;
    wr(6'h06, 9'h100);
    cnt(240, 0, c);
    near("pll_path", 60, c);
    cnt(240, 3, c);
    near("gpio_clk", 30, c);
    @(posedge CORE_CLK);
    run_p <= 1'b0;
    run_m <= 1'b1;
    cnt(40, 0, c);
    near("pll_stop", 0, c);
  endtask
  task t_bclk;
    for (int i = 0; i < 8; i++)
    begin
      wr(6'h06, {4'h0, i[2:0], 2'h1});
      chk("bclk_oe", 24'h1, {23'h0, bclk_oe});
      cnt(128, 1, c);
      near("bclk", 64 >> ((i > 5) ? 5 : i), c);
    end
    wr(6'h06, 9'h001);
    cnt(512, 2, c);
    near("frame", 2, c);
    wr(6'h06, 9'h000);
    chk("frame_oe", 24'h0, {23'h0, frame_oe});
    @(negedge CORE_CLK);
    chk("bint", {23'h0, !bclk_p}, {23'h0, bint});
  endtask
  task t_misc;
    wr(6'h05, 9'h001);
    chk("dac_path", 24'h1, {23'h0, dac_path});
    chk("adc_path", 24'h1, {23'h0, adc_path});
    wr(6'h05, 9'h040);
    chk("dac_path", 24'h0, {23'h0, dac_path});
    chk("adc_path", 24'h0, {23'h0, adc_path});
    for (int i = 0; i < 8; i++)
    begin
      wr(6'h07, {5'h00, i[2:0], 1'b0});
      chk("coef", {21'h0, i[2:0]}, {21'h0, coef});
      chk("rvalid", {23'h0, i < 6}, {23'h0, rvalid});
    end
    wr(6'h04, 9'h060);
    chk("wlen", 24'h2, {22'h0, eff_wlen});
    wr(6'h04, 9'h068);
    chk("wlen", 24'h3, {22'h0, eff_wlen});
  endtask
  initial
  begin
    NRST = 1'b0; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 6'h00; REG_WDATA = 9'h000;
    run_m = 1'b1; run_p = 1'b0; adc_if = 1'b1; dac_pin = 1'b0; dac_if = 1'b0; adc_core = 1'b1;
    n_errors = 0; n_checks = 0; cyc = 0;
    repeat (16) @(posedge CORE_CLK);
    NRST <= 1'b1;
    t_regs;
    t_div;
    t_bclk;
    t_misc;
    print_verdict;
  end
endmodule
`default_nettype wire
